// >>> hdl/shr_map.vh
// Constants of the serial host command interpreter: command codes,
// word lengths, buffer sizes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef SHR_MAP_VH
`define SHR_MAP_VH
// ****************
// Command codes
// ****************
`define SHR_CMD_PROG_WR 8'hB8
`define SHR_CMD_COEF_WR 8'hB4
`define SHR_CMD_OFS_WR 8'hB2
`define SHR_CMD_ACC_WR 8'hBB
`define SHR_CMD_EXEC_C 8'hA4
`define SHR_CMD_EXEC_O 8'hA2
`define SHR_CMD_JUMP 8'hF4
`define SHR_CMD_CRC_WR 8'hF2
`define SHR_CMD_R26_WR 8'hE6
`define SHR_CMD_R2A_WR 8'hEA
`define SHR_CMD_PROG_RD 8'h38
`define SHR_CMD_COEF_RD 8'h34
`define SHR_CMD_OFS_RD 8'h32
`define SHR_CMD_ACC_RD 8'h3B
`define SHR_CMD_PREP_RD 8'h24
`define SHR_CMD_ID 8'h60
`define SHR_CMD_R26_RD 8'h66
`define SHR_CMD_R2A_RD 8'h6A
`define SHR_CMD_STATUS 8'h70
`define SHR_CMD_CRC_RD 8'h72
`define SHR_CMD_MON1 8'h76
`define SHR_CMD_MON2 8'h78
`define SHR_CMD_MON3 8'h7A
`define SHR_CMD_MON4 8'h7C
`define SHR_PREPC_HI 4'h8
`define SHR_PREPO_HI 4'h9
`define SHR_REGWR_HI 3'h6
`define SHR_REGRD_HI 3'h2
// ****************
// Word lengths in bytes and last bit index of a byte
// ****************
`define SHR_LEN_PROG 3'h5
`define SHR_LEN_WORD 3'h3
`define SHR_LEN_MON 3'h4
`define SHR_LEN_TWO 3'h2
`define SHR_LEN_BYTE 3'h1
`define SHR_BIT_LAST 3'h7
// ****************
// Preparation buffer and reset values
// ****************
`define SHR_PREP_DEPTH 16
`define SHR_PREP_BEYOND 24'h000001
// Arbitrary identification value
`define SHR_ID_CODE 8'h3C
`define SHR_JUMP_RST 8'h00
`define SHR_CRC_RST 16'h0000
`define SHR_PIN_RST 3'h4
`endif

// >>> hdl/shr_prep_mem.v
// Preparation buffer: sixteen 24-bit words, one write port and two
// registered read ports (host read-back and DSP commit).
// Assumes a single clock shared with the command interpreter.
`timescale 1ns/1ns
`default_nettype none
`include "shr_map.vh"
module shr_prep_mem (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Write port
  input wire we,
  input wire [3:0] waddr,
  input wire [23:0] wdata,
  // Read ports
  input wire [3:0] raddr_a,
  output reg [23:0] rdata_a,
  input wire [3:0] raddr_b,
  output reg [23:0] rdata_b
);
  reg [23:0] mem [0:`SHR_PREP_DEPTH-1];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (reset) begin
      rdata_a <= 24'h000000;
      rdata_b <= 24'h000000;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule
`default_nettype wire

// >>> hdl/shr_host_port.v
// Serial host command interpreter: decodes command, address and data
// bytes from the serial port into DSP RAM, register and status access.
// Assumes ram_rdata and reg_rdata are valid the cycle after the read
// strobe, and a serial clock half period of at least six mclk cycles.
//
// How it works
// R01: Echo mode returns input bytes one byte late
// R02: Extra echo-check bytes write the next address
// R03: Read skips echo of second address byte
// R04: Program write 0xB8, five bytes, 36-bit word
// R05: Coefficient write 0xB4, 11-bit address, 24-bit words
// R06: Offset write 0xB2, 6-bit address, 13-bit value
// R07: Accelerator write 0xBB, 20-bit left-justified word
// R08: Control register write, command then one byte
// R09: Jump code write 0xF4 with one byte
// R10: CRC reference 0xF2, two bytes, high first
// R11: 0x80-0x8F prepares 1 to 16 coefficients
// R12: 0x90-0x9F prepares 1 to 16 offsets
// R13: Prepared words beyond the count are dropped
// R14: 0xA4 or 0xA2 with zero address commits
// R15: RAM reads in reset mirror write layouts
// R16: Control register reads return one byte
// R17: Identification byte and two-byte CRC result
// R18: Status byte carries fault, flag, lock bits
// R19: Monitor reads return four bytes with flags
// R20: Preparation read: address, words, then 0x000001
// R21: Address steps by one; program starts at 0
// R22: Host waits two frames before preparing
// R23: Command bit 7 selects write or read
// R24: Host waits for ready after commit
// R25: Deselect abandons the command in progress
`timescale 1ns/1ns
`default_nettype none
`include "shr_map.vh"
module shr_host_port (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Serial host pins
  input wire sclk,
  input wire si,
  input wire chip_select_n,
  output reg so,
  output reg so_oe,
  // Operating mode
  input wire echo_mode,
  input wire dsp_reset_control_n,
  // DSP RAM port
  output reg ram_wr,
  output reg ram_rd,
  output reg [1:0] ram_sel,
  output reg [11:0] ram_addr,
  output reg [35:0] ram_wdata,
  input wire [35:0] ram_rdata,
  // Control registers
  output reg reg_wr,
  output reg reg_rd,
  output reg [5:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Jump code and CRC
  output reg [7:0] jump_code,
  output reg jump_load,
  output reg [15:0] crc_reference,
  input wire [15:0] crc_result,
  // Error status sources
  input wire crc_fault_n,
  input wire watchdog_fault_n,
  input wire general_flag_a,
  input wire general_flag_b,
  input wire pll_locked,
  // Monitor words
  input wire [31:0] monitor_word_1,
  input wire [31:0] monitor_word_2,
  input wire [31:0] monitor_word_3,
  input wire [31:0] monitor_word_4,
  // Prepared update
  output reg commit_coef,
  output reg commit_ofs,
  output reg prep_is_ofs,
  output reg [10:0] prep_base,
  output reg [4:0] prep_count,
  input wire [3:0] dsp_prep_idx,
  output wire [23:0] dsp_prep_data
);
  localparam [2:0] ST_CMD = 3'h0;
  localparam [2:0] ST_ADR1 = 3'h1;
  localparam [2:0] ST_ADR2 = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_RDAT = 3'h4;
  localparam [2:0] ST_SKIP = 3'h5;
  localparam [3:0] OP_PROG = 4'h0;
  localparam [3:0] OP_COEF = 4'h1;
  localparam [3:0] OP_OFS = 4'h2;
  localparam [3:0] OP_ACC = 4'h3;
  localparam [3:0] OP_PREPC = 4'h4;
  localparam [3:0] OP_PREPO = 4'h5;
  localparam [3:0] OP_EXEC = 4'h6;
  localparam [3:0] OP_REG = 4'h7;
  localparam [3:0] OP_JUMP = 4'h8;
  localparam [3:0] OP_CRC = 4'h9;
  localparam [3:0] OP_PREPRD = 4'hA;
  localparam [3:0] OP_ID = 4'hB;
  localparam [3:0] OP_STAT = 4'hC;
  localparam [3:0] OP_CRCRD = 4'hD;
  localparam [3:0] OP_MON = 4'hE;
  localparam [2:0] PIN_RST = `SHR_PIN_RST;

  // ****************
  // Pin synchronisers
  // ****************
  wire [2:0] pin_in;
  wire [2:0] pin_f;
  assign pin_in = {chip_select_n, si, sclk};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg f;
      always @(posedge mclk) begin
        if (reset) begin
          s1 <= PIN_RST[g];
          s2 <= PIN_RST[g];
          s3 <= PIN_RST[g];
          f <= PIN_RST[g];
        end else begin
          s1 <= pin_in[g];
          s2 <= s1;
          s3 <= s2;
          // Glitch of one sample never reaches the decoder
          if (s2 == s3) begin
            f <= s3;
          end
        end
      end
      assign pin_f[g] = f;
    end
  endgenerate

  reg sclk_q;
  wire sel = ~pin_f[2];
  wire rise = sel & pin_f[0] & ~sclk_q;
  wire fall = sel & ~pin_f[0] & sclk_q;

  // ****************
  // State
  // ****************
  reg [2:0] state;
  reg [3:0] op;
  reg [7:0] cmd;
  reg rd_mode;
  reg [2:0] bit_cnt;
  reg [7:0] rx;
  reg [7:0] rx_last;
  reg byte_done;
  reg [2:0] byte_idx;
  reg [2:0] word_len;
  reg [31:0] wbuf;
  reg [7:0] addr_hi;
  reg [11:0] cur_addr;
  reg [39:0] rd_word;
  reg [7:0] tx;
  reg [3:0] ld;
  reg fetch;
  reg [1:0] fe;
  reg [4:0] widx;
  reg [4:0] ridx;
  reg pr_first;
  reg pm_we;
  reg [3:0] pm_waddr;
  reg [23:0] pm_wdata;
  reg [3:0] pm_raddr;
  wire [23:0] pm_q;
  wire [39:0] w40 = {wbuf, rx_last};
  wire [39:0] rd_sh = rd_word << {byte_idx, 3'h0};
  wire [7:0] status = {crc_fault_n, watchdog_fault_n, general_flag_a,
                       general_flag_b, pll_locked, 3'h0};
  reg [31:0] mon_sel;

  shr_prep_mem u_prep (
    .mclk(mclk),
    .reset(reset),
    .we(pm_we),
    .waddr(pm_waddr),
    .wdata(pm_wdata),
    .raddr_a(pm_raddr),
    .rdata_a(pm_q),
    .raddr_b(dsp_prep_idx),
    .rdata_b(dsp_prep_data)
  );

  always @* begin
    case (cmd[3:1])
      3'h3: mon_sel = monitor_word_1;
      3'h4: mon_sel = monitor_word_2;
      3'h5: mon_sel = monitor_word_3;
      default: mon_sel = monitor_word_4;
    endcase
  end

  // ****************
  // Command decode
  // ****************
  reg [3:0] d_op;
  reg d_rd;
  reg d_adr;
  reg d_ok;
  reg [2:0] d_len;
  wire run = dsp_reset_control_n;

  always @* begin
    d_op = OP_ID;
    d_rd = ~rx_last[7]; // R23
    d_adr = 1'b0;
    d_ok = 1'b1;
    d_len = `SHR_LEN_BYTE;
    case (rx_last)
      `SHR_CMD_PROG_WR, `SHR_CMD_PROG_RD: begin
        d_op = OP_PROG; // R04 R15
        d_adr = 1'b1;
        d_len = `SHR_LEN_PROG;
        d_ok = ~run;
      end
      `SHR_CMD_COEF_WR, `SHR_CMD_COEF_RD: begin
        d_op = OP_COEF; // R05 R15
        d_adr = 1'b1;
        d_len = `SHR_LEN_WORD;
        d_ok = ~run;
      end
      `SHR_CMD_OFS_WR, `SHR_CMD_OFS_RD: begin
        d_op = OP_OFS; // R06 R15
        d_adr = 1'b1;
        d_len = `SHR_LEN_WORD;
        d_ok = ~run;
      end
      `SHR_CMD_ACC_WR, `SHR_CMD_ACC_RD: begin
        d_op = OP_ACC; // R07 R15
        d_adr = 1'b1;
        d_len = `SHR_LEN_WORD;
        d_ok = ~run;
      end
      `SHR_CMD_EXEC_C, `SHR_CMD_EXEC_O: begin
        d_op = OP_EXEC; // R14
        d_adr = 1'b1;
        d_ok = run;
      end
      `SHR_CMD_JUMP: d_op = OP_JUMP; // R09
      `SHR_CMD_CRC_WR: begin
        d_op = OP_CRC; // R10
        d_len = `SHR_LEN_TWO;
      end
      `SHR_CMD_R26_WR, `SHR_CMD_R2A_WR, `SHR_CMD_R26_RD, `SHR_CMD_R2A_RD: begin
        d_op = OP_REG; // R08 R16
      end
      `SHR_CMD_PREP_RD: begin
        d_op = OP_PREPRD; // R20
        d_len = `SHR_LEN_TWO;
        d_ok = run;
      end
      `SHR_CMD_ID: d_op = OP_ID; // R17
      `SHR_CMD_STATUS: d_op = OP_STAT; // R18
      `SHR_CMD_CRC_RD: begin
        d_op = OP_CRCRD; // R17
        d_len = `SHR_LEN_TWO;
      end
      `SHR_CMD_MON1, `SHR_CMD_MON2, `SHR_CMD_MON3, `SHR_CMD_MON4: begin
        d_op = OP_MON; // R19
        d_len = `SHR_LEN_MON;
      end
      default: begin
        if (rx_last[7:4] == `SHR_PREPC_HI || rx_last[7:4] == `SHR_PREPO_HI) begin
          d_op = rx_last[4] ? OP_PREPO : OP_PREPC; // R11 R12
          d_adr = 1'b1;
          d_len = `SHR_LEN_WORD;
          d_ok = run;
        end else if (rx_last[7:5] == `SHR_REGWR_HI || rx_last[7:5] == `SHR_REGRD_HI) begin
          d_op = OP_REG; // R08 R16
        end else begin
          d_ok = 1'b0;
        end
      end
    endcase
  end

  // ****************
  // Serial engine and byte sequencer
  // ****************
  always @(posedge mclk) begin
    if (reset) begin
      sclk_q <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
      state <= ST_CMD;
      op <= OP_ID;
      cmd <= 8'h00;
      rd_mode <= 1'b0;
      bit_cnt <= 3'h0;
      rx <= 8'h00;
      rx_last <= 8'h00;
      byte_done <= 1'b0;
      byte_idx <= 3'h0;
      word_len <= `SHR_LEN_BYTE;
      wbuf <= 32'h00000000;
      addr_hi <= 8'h00;
      cur_addr <= 12'h000;
      rd_word <= 40'h0000000000;
      tx <= 8'h00;
      ld <= 4'h0;
      fetch <= 1'b0;
      fe <= 2'h0;
      widx <= 5'h00;
      ridx <= 5'h00;
      pr_first <= 1'b0;
      pm_we <= 1'b0;
      pm_waddr <= 4'h0;
      pm_wdata <= 24'h000000;
      pm_raddr <= 4'h0;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      ram_sel <= 2'h0;
      ram_addr <= 12'h000;
      ram_wdata <= 36'h000000000;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 6'h00;
      reg_wdata <= 8'h00;
      jump_code <= `SHR_JUMP_RST;
      jump_load <= 1'b0;
      crc_reference <= `SHR_CRC_RST;
      commit_coef <= 1'b0;
      commit_ofs <= 1'b0;
      prep_is_ofs <= 1'b0;
      prep_base <= 11'h000;
      prep_count <= 5'h00;
    end else begin
      sclk_q <= pin_f[0];
      so_oe <= sel;
      byte_done <= 1'b0;
      fetch <= 1'b0;
      ld <= {ld[2:0], byte_done};
      fe <= {fe[0], fetch};
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      jump_load <= 1'b0;
      commit_coef <= 1'b0;
      commit_ofs <= 1'b0;
      pm_we <= 1'b0;
      if (!sel) begin
        bit_cnt <= 3'h0; // R25
        state <= ST_CMD; // R25
        so <= 1'b0;
      end else begin
        if (rise) begin
          rx <= {rx[6:0], pin_f[1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `SHR_BIT_LAST) begin
            byte_done <= 1'b1;
            rx_last <= {rx[6:0], pin_f[1]};
          end
        end
        // A load landing on a falling edge would lose one bit
        if (ld[3]) begin
          if (state == ST_RDAT) begin
            tx <= rd_sh[39:32]; // R03
          end else begin
            tx <= echo_mode ? rx_last : 8'h00; // R01
          end
        end else if (fall) begin
          so <= tx[7];
          tx <= {tx[6:0], 1'b0};
        end
        if (byte_done) begin
          case (state)
            ST_CMD: begin
              cmd <= rx_last;
              op <= d_op;
              rd_mode <= d_rd;
              word_len <= d_len;
              byte_idx <= 3'h0;
              pr_first <= 1'b1;
              ridx <= 5'h00;
              if (!d_ok) begin
                state <= ST_SKIP;
              end else if (d_adr) begin
                state <= ST_ADR1;
              end else if (d_rd) begin
                state <= ST_RDAT;
                fetch <= 1'b1;
              end else begin
                state <= ST_WDAT;
              end
            end
            ST_ADR1: begin
              addr_hi <= rx_last;
              state <= ST_ADR2;
            end
            ST_ADR2: begin
              case (op)
                OP_PROG: cur_addr <= 12'h000; // R21
                OP_OFS: cur_addr <= {6'h00, rx_last[5:0]}; // R06
                default: cur_addr <= {1'b0, addr_hi[2:0], rx_last}; // R05 R07
              endcase
              if (op == OP_PREPC || op == OP_PREPO) begin
                prep_is_ofs <= (op == OP_PREPO);
                if (op == OP_PREPO) begin
                  prep_base <= {6'h00, rx_last[4:0]}; // R12
                end else begin
                  prep_base <= {addr_hi[2:0], rx_last}; // R11
                end
                prep_count <= {1'b0, cmd[3:0]} + 5'h01; // R11 R12
                widx <= 5'h00;
              end
              if (op == OP_EXEC) begin
                commit_coef <= cmd[2]; // R14
                commit_ofs <= ~cmd[2]; // R14
                state <= ST_SKIP;
              end else if (rd_mode) begin
                state <= ST_RDAT;
                fetch <= 1'b1;
              end else begin
                state <= ST_WDAT;
              end
            end
            ST_WDAT: begin
              wbuf <= {wbuf[23:0], rx_last};
              if (byte_idx == word_len - 3'h1) begin
                byte_idx <= 3'h0;
                case (op)
                  OP_PROG, OP_COEF, OP_OFS, OP_ACC: begin
                    ram_wr <= 1'b1;
                    ram_sel <= op[1:0];
                    ram_addr <= cur_addr;
                    cur_addr <= cur_addr + 12'h001; // R21 R02
                    case (op)
                      OP_PROG: ram_wdata <= w40[35:0]; // R04
                      OP_COEF: ram_wdata <= {12'h000, w40[23:0]}; // R05
                      OP_OFS: ram_wdata <= {23'h00000, w40[12:0]}; // R06
                      default: ram_wdata <= {16'h0000, w40[23:4]}; // R07
                    endcase
                  end
                  OP_PREPC, OP_PREPO: begin
                    if (widx < prep_count) begin
                      pm_we <= 1'b1; // R13
                      pm_waddr <= widx[3:0];
                      widx <= widx + 5'h01;
                    end
                    if (op == OP_PREPO) begin
                      pm_wdata <= {11'h000, w40[12:0]}; // R12
                    end else begin
                      pm_wdata <= w40[23:0]; // R11
                    end
                  end
                  OP_REG: begin
                    reg_wr <= 1'b1; // R08
                    reg_addr <= cmd[5:0];
                    reg_wdata <= rx_last;
                    state <= ST_SKIP;
                  end
                  OP_JUMP: begin
                    jump_code <= rx_last; // R09
                    jump_load <= 1'b1;
                    state <= ST_SKIP;
                  end
                  OP_CRC: begin
                    crc_reference <= w40[15:0]; // R10
                    state <= ST_SKIP;
                  end
                  default: state <= ST_SKIP;
                endcase
              end else begin
                byte_idx <= byte_idx + 3'h1;
              end
            end
            ST_RDAT: begin
              if (byte_idx == word_len - 3'h1) begin
                byte_idx <= 3'h0;
                fetch <= 1'b1;
                if (op < OP_PREPC) begin
                  cur_addr <= cur_addr + 12'h001; // R21 R15
                end
                if (op == OP_PREPRD) begin
                  if (pr_first) begin
                    pr_first <= 1'b0;
                    word_len <= `SHR_LEN_WORD;
                  end else if (ridx != `SHR_PREP_DEPTH) begin
                    ridx <= ridx + 5'h01;
                  end
                end
              end else begin
                byte_idx <= byte_idx + 3'h1;
              end
            end
            default: state <= ST_SKIP;
          endcase
        end
      end
      // ****************
      // Read fetch and capture
      // ****************
      if (fetch) begin
        ram_sel <= op[1:0];
        ram_addr <= cur_addr;
        reg_addr <= cmd[5:0];
        pm_raddr <= ridx[3:0];
        ram_rd <= (op < OP_PREPC);
        reg_rd <= (op == OP_REG); // R16
      end
      if (fe[1]) begin
        case (op)
          OP_PROG: rd_word <= {4'h0, ram_rdata}; // R15
          OP_COEF: rd_word <= {ram_rdata[23:0], 16'h0000}; // R15
          OP_OFS: rd_word <= {11'h000, ram_rdata[12:0], 16'h0000}; // R15
          OP_ACC: rd_word <= {ram_rdata[19:0], 20'h00000}; // R15
          OP_REG: rd_word <= {reg_rdata, 32'h00000000}; // R16
          OP_ID: rd_word <= {`SHR_ID_CODE, 32'h00000000}; // R17
          OP_STAT: rd_word <= {status, 32'h00000000}; // R18
          OP_CRCRD: rd_word <= {crc_result, 24'h000000}; // R17
          OP_MON: rd_word <= {mon_sel, 8'h00}; // R19
          OP_PREPRD: begin
            if (pr_first) begin
              rd_word <= {5'h00, prep_base, 24'h000000}; // R20
            end else if (ridx < prep_count) begin
              rd_word <= {pm_q, 16'h0000}; // R20
            end else begin
              rd_word <= {`SHR_PREP_BEYOND, 16'h0000}; // R20
            end
          end
          default: rd_word <= 40'h0000000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/shr_host_port_asserts.sv
// Checker for the serial host command interpreter, mclk domain only.
// Assumes binding onto shr_host_port, serial pins synchronised inside.
`timescale 1ns/1ns
`default_nettype none
module shr_host_port_asserts (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Observed ports
  input wire chip_select_n,
  input wire dsp_reset_control_n,
  input wire so,
  input wire so_oe,
  input wire ram_wr,
  input wire ram_rd,
  input wire reg_wr,
  input wire jump_load,
  input wire commit_coef,
  input wire commit_ofs,
  input wire [4:0] prep_count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Six cycles covers the synchroniser lag
  sequence s_idle;
    chip_select_n [*6];
  endsequence
  sequence s_running;
    dsp_reset_control_n [*8];
  endsequence
  chk_idle_quiet: assert property (s_idle |-> !ram_wr && !reg_wr && !commit_coef)
    else $error("write strobe while deselected");
  chk_oe_release: assert property ($rose(chip_select_n) |-> ##[2:6] !so_oe)
    else $error("so_oe kept after deselect");
  chk_idle_low: assert property (!so_oe && !$past(so_oe) |-> !so)
    else $error("so not low while deselected");
  chk_ram_pulse: assert property (ram_wr |=> !ram_wr)
    else $error("ram_wr longer than one cycle");
  chk_reg_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("reg_wr longer than one cycle");
  chk_jump_pulse: assert property (jump_load |=> !jump_load)
    else $error("jump_load longer than one cycle");
  chk_commit_run: assert property (commit_coef || commit_ofs |->
    dsp_reset_control_n && !(commit_coef && commit_ofs))
    else $error("commit outside run or both kinds");
  chk_prep_range: assert property ($changed(prep_count) |-> prep_count inside {[1:16]})
    else $error("prepared count out of range");
  chk_run_no_ramrd: assert property (s_running |-> !ram_rd)
    else $error("RAM read while running");
endmodule
bind shr_host_port shr_host_port_asserts shr_host_port_asserts_i (.*);
`default_nettype wire

// >>> testbench/shr_host_model.sv
// Host serial master model: bytes MSB first, data set while clock low.
// Assumes mclk of 4 ns; serial clock period 16 mclk, idle low.
`timescale 1ns/1ns
`default_nettype none
module shr_host_model (
  // Clock
  input wire mclk,
  // Serial pins
  output logic sclk,
  output logic si,
  output logic chip_select_n,
  input wire so
);
  initial begin
    sclk = 1'b0;
    si = 1'b0;
    chip_select_n = 1'b1;
  end
  // One byte out and one in; so sampled at the rising edge
  task automatic xb(input logic [7:0] t, output logic [7:0] r);
    if (chip_select_n) begin
      chip_select_n = 1'b0;
      repeat (8) @(negedge mclk);
    end
    for (int i = 7; i >= 0; i--) begin
      si = t[i];
      repeat (8) @(negedge mclk);
      sclk = 1'b1;
      r[i] = so;
      repeat (8) @(negedge mclk);
      sclk = 1'b0;
    end
  endtask
  // Clock stands still; si no longer carries the last bit
  task automatic desel;
    @(negedge mclk);
    chip_select_n = 1'b1;
    si = ~si;
    repeat (12) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> testbench/shr_host_port_tb_top.sv
// Self-checking bench for shr_host_port with DSP RAM and register models.
// Assumes the host model drives the serial pins at mclk falling edges.
`timescale 1ns/1ns
`default_nettype none
`include "shr_map.vh"
module shr_host_port_tb_top;
  logic mclk = 0, reset = 1, echo_mode = 0, dsp_reset_control_n = 0;
  wire sclk, si, chip_select_n;
  logic so, so_oe, ram_wr, ram_rd, reg_wr, reg_rd, jump_load;
  logic commit_coef, commit_ofs, prep_is_ofs;
  logic [1:0] ram_sel;
  logic [11:0] ram_addr;
  logic [35:0] ram_wdata, ram_rdata = 0;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata = 0, jump_code;
  logic [15:0] crc_reference, crc_result = 0;
  logic [4:0] flags = 0, prep_count;
  logic [31:0] mon [4] = '{0, 0, 0, 0};
  logic [10:0] prep_base;
  logic [3:0] dsp_prep_idx = 0;
  logic [23:0] dsp_prep_data;
  logic [35:0] mem [logic [13:0]];
  logic [7:0] rg [64];
  logic [7:0] tx [$], rx [$];
  logic [11:0] wa [$];
  logic [35:0] wd [$];
  logic [7:0] cmds [4] = '{8'hB8, 8'hB4, 8'hB2, 8'hBB};
  int bad_count = 0, samples_checked = 0, cyc = 0;
  integer ncc = 0, nco = 0;
  always #2 mclk = ~mclk;
  shr_host_model shr_host_model_i (.*);
  shr_host_port shr_host_port_i (.crc_fault_n(flags[4]), .watchdog_fault_n(flags[3]),
    .general_flag_a(flags[2]), .general_flag_b(flags[1]), .pll_locked(flags[0]),
    .monitor_word_1(mon[0]), .monitor_word_2(mon[1]), .monitor_word_3(mon[2]),
    .monitor_word_4(mon[3]), .*);
  // ****************
  // DSP side models
  // ****************
  always @(posedge mclk) begin
    if (ram_wr) begin
      mem[{ram_sel, ram_addr}] = ram_wdata;
      wa.push_back(ram_addr);
      wd.push_back(ram_wdata);
    end
    if (ram_rd) ram_rdata <= mem.exists({ram_sel, ram_addr}) ? mem[{ram_sel, ram_addr}] : 0;
    if (reg_wr) rg[reg_addr] <= reg_wdata;
    if (reg_rd) reg_rdata <= rg[reg_addr];
    ncc += commit_coef;
    nco += commit_ofs;
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      conclude;
    end
  end
  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [35:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame;
    logic [7:0] r;
    rx = {};
    foreach (tx[i]) begin
      shr_host_model_i.xb(tx[i], r);
      rx.push_back(r);
    end
    shr_host_model_i.desel;
  endtask
  // Byte image of a word as it travels on the wire
  function automatic logic [39:0] wire_form(input int s, input logic [35:0] v);
    return s == 3 ? {16'h0, v[19:0], 4'h0} : {4'h0, v};
  endfunction
  // Two words, one stray byte, then read back both words
  task automatic ram_test(input int s);
    logic [35:0] v [2];
    logic [39:0] b;
    logic [10:0] a;
    int n, w;
    n = s ? 3 : 5;
    w = s == 0 ? 36 : s == 2 ? 13 : s == 1 ? 24 : 20;
    a = s == 0 ? 0 : $urandom & (s == 2 ? 63 : 2047);
    wa = {};
    wd = {};
    tx = {cmds[s], 8'(a >> 8), a[7:0]};
    for (int k = 0; k < 2; k++) begin
      v[k] = {$urandom, $urandom} & ((36'h1 << w) - 1);
      b = wire_form(s, v[k]);
      for (int j = n - 1; j >= 0; j--) tx.push_back(b[8 * j +: 8]);
    end
    tx.push_back(8'h5A);
    frame;
    check(wa.size(), 2);
    for (int k = 0; k < 2; k++) begin
      check(wa[k], a + k);
      check(wd[k], v[k]);
    end
    if (echo_mode) for (int i = 1; i < tx.size(); i++) check(rx[i], tx[i - 1]);
    tx = {cmds[s] & 8'h7F, 8'(a >> 8), a[7:0]};
    repeat (2 * n) tx.push_back(8'($urandom));
    frame;
    for (int k = 0; k < 2; k++) begin
      b = wire_form(s, v[k]);
      for (int j = 0; j < n; j++) check(rx[3 + k * n + j], b[8 * (n - 1 - j) +: 8]);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [5:0] ra [4] = '{6'h00, 6'h1F, 6'h26, 6'h2A};
    logic [7:0] d;
    logic [10:0] a;
    logic [23:0] pw [4];
    integer c0, o0;
    void'($urandom(78146));
    repeat (2) @(negedge mclk);
    reset = 0;
    repeat (4) @(negedge mclk);
    for (int e = 0; e < 2; e++) begin
      echo_mode = e;
      for (int s = 0; s < 4; s++) ram_test(s);
      $display("RAM access test done, echo %0d", e);
    end
    echo_mode = 0;
    dsp_reset_control_n = 1;
    foreach (ra[i]) begin
      d = $urandom;
      tx = {8'hC0 | ra[i], d};
      frame;
      tx = {8'h40 | ra[i], 8'h00};
      frame;
      check(rx[1], d);
    end
    $display("Control register test done");
    d = $urandom;
    crc_result = $urandom;
    flags = $urandom;
    foreach (mon[m]) mon[m] = $urandom;
    tx = {8'hF4, d};
    frame;
    check(jump_code, d);
    tx = {8'hF2, d, ~d};
    frame;
    check(crc_reference, {d, ~d});
    tx = {8'h60, 8'h00};
    frame;
    check(rx[1], `SHR_ID_CODE);
    tx = {8'h72, 8'h00, 8'h00};
    frame;
    check({rx[1], rx[2]}, crc_result);
    tx = {8'h70, 8'h00};
    frame;
    check(rx[1], {flags, 3'h0});
    for (int m = 0; m < 4; m++) begin
      tx = {8'h76 + 8'(2 * m), 8'h00, 8'h00, 8'h00, 8'h00};
      frame;
      check({rx[1], rx[2], rx[3], rx[4]}, mon[m]);
    end
    $display("Status read test done");
    for (int o = 0; o < 2; o++) begin
      a = $urandom & (o ? 31 : 2047);
      tx = {o ? 8'h92 : 8'h82, 8'(a >> 8), a[7:0]};
      for (int k = 0; k < 4; k++) begin
        pw[k] = o ? $urandom & 13'h1FFF : $urandom;
        tx = {tx, pw[k][23:16], pw[k][15:8], pw[k][7:0]};
      end
      frame;
      check(prep_count, 3);
      check(prep_base, a);
      check(prep_is_ofs, o);
      dsp_prep_idx = 2;
      repeat (2) @(negedge mclk);
      check(dsp_prep_data, pw[2]);
      tx = {8'h24};
      repeat (14) tx.push_back(8'h00);
      frame;
      check({rx[1], rx[2]}, a);
      for (int k = 0; k < 4; k++)
        check({rx[3 + 3 * k], rx[4 + 3 * k], rx[5 + 3 * k]}, k < 3 ? pw[k] : `SHR_PREP_BEYOND);
      c0 = ncc;
      o0 = nco;
      tx = {o ? 8'hA2 : 8'hA4, 8'h00, 8'h00};
      frame;
      check(ncc - c0, !o);
      check(nco - o0, o);
    end
    $display("Prepared update test done");
    conclude;
  end
endmodule
`default_nettype wire
